/* irq_group_pkg.sv */
// constants for the vectored interrupt group control block
package irq_group_pkg;
    localparam int unsigned NUM_GROUPS = 19;
    localparam int unsigned SRC_BITS = 31;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned VEC_W = 18;
    // register byte addresses
    localparam logic [11:0] CONTROL_OFS = 12'h500;
    localparam logic [11:0] PENDING_OFS = 12'h504;
    localparam logic [11:0] ENABLE_SET_OFS = 12'h508;
    localparam logic [11:0] ENABLE_CLEAR_OFS = 12'h50c;
    localparam logic [11:0] ACTIVE_OFS = 12'h510;
    localparam logic [11:0] IRQ_STATUS_OFS = 12'h514;
    localparam logic [11:0] IRQ_MASK_OFS = 12'h518;
    // control register fields
    localparam int unsigned SOFT_RESET_BIT = 0;
    localparam int unsigned SPACING_BIT = 8;
    // vector spacing in bytes, as shift amounts
    localparam int unsigned SPACING_SMALL_SHIFT = 3;
    localparam int unsigned SPACING_LARGE_SHIFT = 9;
    // reset values
    localparam logic [NUM_GROUPS-1:0] ENABLE_RESET = 19'h00000;
    localparam logic [31:0] CONTROL_RESET = 32'h00000000;
endpackage

/* irq_group_ctrl.sv */
// group aggregation, enables and vectors of a jump-table interrupt controller
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// ---------------------------------------------------------------------
module irq_group_ctrl (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // register port
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // per-group sources, their enables and aggregator control words
    input wire logic [18:0][30:0] src_status,
    input wire logic [18:0][30:0] src_enable,
    input wire logic [18:0][17:0] aggr_ctrl,
    // toward the processor core
    output logic [18:0] group_vector_req,
    output logic [18:0][17:0] group_vector_addr,
    output logic irq
);
    typedef struct packed {
        logic soft_reset;
        logic spacing;
        logic [18:0] enable;
        logic [18:0] pending;
        logic [18:0] active;
        logic [18:0][17:0] vec;
        logic [31:0] rdata;
        logic [18:0] stat;
        logic [18:0] mask;
        logic irq;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic [18:0] pend_c;
    logic [18:0] act_c;
    logic [18:0][17:0] vec_c;
    logic [18:0] rise_c;

    // -----------------------------------------------------------------
    // group aggregation
    // -----------------------------------------------------------------
    always_comb begin
        logic [30:0] res;
        logic [4:0] pos;
        res = '0;
        pos = '0;
        for (int g = 0; g < 19; g++) begin
            res = src_status[g] & src_enable[g];
            pend_c[g] = |src_status[g];
            act_c[g] = s_r.enable[g] & (|res);
            pos = '0;
            for (int b = 30; b >= 0; b--) begin
                if (res[b]) begin
                    pos = 5'(b);
                end
            end
            vec_c[g] = {aggr_ctrl[g][17:1], 1'b0};
            if (aggr_ctrl[g][0]) begin
                if (s_r.spacing) begin
                    vec_c[g] = 18'(vec_c[g] +
                        (18'(pos) << irq_group_pkg::SPACING_LARGE_SHIFT));
                end else begin
                    vec_c[g] = 18'(vec_c[g] +
                        (18'(pos) << irq_group_pkg::SPACING_SMALL_SHIFT));
                end
            end
        end
    end

    assign rise_c = act_c & ~s_r.active;

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.rdata = '0;
        s_nxt.pending = pend_c;
        s_nxt.active = act_c;
        s_nxt.vec = vec_c;
        // set wins over a same-cycle write-one clear
        s_nxt.stat = s_r.stat & ~((wr && addr == irq_group_pkg::IRQ_STATUS_OFS)
            ? wdata[18:0] : 19'h00000);
        s_nxt.stat = s_nxt.stat | rise_c;
        if (wr) begin
            unique case (addr)
                irq_group_pkg::CONTROL_OFS: begin
                    s_nxt.soft_reset = wdata[irq_group_pkg::SOFT_RESET_BIT];
                    s_nxt.spacing = wdata[irq_group_pkg::SPACING_BIT];
                end
                irq_group_pkg::ENABLE_SET_OFS:
                    s_nxt.enable = s_r.enable | wdata[18:0];
                irq_group_pkg::ENABLE_CLEAR_OFS:
                    s_nxt.enable = s_r.enable & ~wdata[18:0];
                irq_group_pkg::IRQ_MASK_OFS:
                    s_nxt.mask = wdata[18:0];
                default: ;
            endcase
        end
        if (rd) begin
            unique case (addr)
                irq_group_pkg::CONTROL_OFS:
                    s_nxt.rdata = {23'h000000, s_r.spacing, 7'h00,
                        s_r.soft_reset};
                irq_group_pkg::PENDING_OFS:
                    s_nxt.rdata = {13'h0000, s_r.pending};
                irq_group_pkg::ENABLE_SET_OFS,
                irq_group_pkg::ENABLE_CLEAR_OFS:
                    s_nxt.rdata = {13'h0000, s_r.enable};
                irq_group_pkg::ACTIVE_OFS:
                    s_nxt.rdata = {13'h0000, s_r.active};
                irq_group_pkg::IRQ_STATUS_OFS:
                    s_nxt.rdata = {13'h0000, s_r.stat};
                irq_group_pkg::IRQ_MASK_OFS:
                    s_nxt.rdata = {13'h0000, s_r.mask};
                default: s_nxt.rdata = '0;
            endcase
        end
        s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
        // soft reset clears everything but itself; sources live outside
        if (s_nxt.soft_reset) begin
            s_nxt = '0;
            s_nxt.soft_reset = 1'b1;
            s_nxt.rdata = (rd && addr == irq_group_pkg::CONTROL_OFS)
                ? 32'h00000001 : 32'h00000000;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign group_vector_req = s_r.active;
    assign group_vector_addr = s_r.vec;
    assign irq = s_r.irq;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    a_disabled_inactive: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !s_r.enable[0]) |=> !group_vector_req[0])
        else $error("disabled group presented a vector");

    a_set_enables: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && wr && addr == 12'h508 && wdata[3] && !s_nxt.soft_reset)
        |=> s_r.enable[3])
        else $error("enable set write ignored");

    a_clear_disables: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && wr && addr == 12'h50c && wdata[3]) |=> !s_r.enable[3])
        else $error("enable clear write ignored");

    a_write_zero_keeps: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && wr && addr == 12'h508 && !wdata[0] && !s_nxt.soft_reset)
        |=> s_r.enable[0] == $past(s_r.enable[0]))
        else $error("enable set zero changed enable");

    a_clear_zero_keeps: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && wr && addr == 12'h50c && !wdata[0] && !s_nxt.soft_reset)
        |=> s_r.enable[0] == $past(s_r.enable[0]))
        else $error("enable clear zero changed enable");

    a_pending_or: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !s_nxt.soft_reset)
        |=> s_r.pending[5] == $past(|src_status[5]))
        else $error("pending not or of sources");

    a_pending_high: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !s_nxt.soft_reset)
        |=> s_r.pending[18] == $past(|src_status[18]))
        else $error("top group pending not or of sources");

    a_soft_reset_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && s_nxt.soft_reset) |=> (s_r.enable == 19'h0 && !irq))
        else $error("soft reset did not clear state");

    a_soft_reset_quiet: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && s_nxt.soft_reset)
        |=> (group_vector_req == 19'h0 && rdata[31:1] == 31'h0))
        else $error("soft reset left outputs up");

    a_active_result: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !s_nxt.soft_reset && s_r.enable[1]
            && |(src_status[1] & src_enable[1])) |=> group_vector_req[1])
        else $error("enabled result not presented");

    a_active_off: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && (src_status[0] & src_enable[0]) == 31'h0)
        |=> !group_vector_req[0])
        else $error("vector without enabled result");

    a_vector_base: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !s_nxt.soft_reset && !aggr_ctrl[2][0])
        |=> group_vector_addr[2] == {$past(aggr_ctrl[2][17:1]), 1'b0})
        else $error("aggregated vector not base");

    a_spacing_large: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !s_nxt.soft_reset && s_r.spacing && aggr_ctrl[4][0]
            && aggr_ctrl[4][17:1] == 17'h0 && src_status[4][1:0] == 2'b10
            && src_enable[4][1])
        |=> group_vector_addr[4] == 18'h00200)
        else $error("spacing of 512 not applied");

    // group 0 with source 5 the lowest one set: position 5 times the spacing
    a_spacing_small: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !s_nxt.soft_reset && !s_r.spacing && aggr_ctrl[0][0]
            && src_status[0][5:0] == 6'h20 && src_enable[0][5])
        |=> group_vector_addr[0] ==
            18'({$past(aggr_ctrl[0][17:1]), 1'b0} + 18'h00028))
        else $error("spacing of 8 not applied");

    a_spacing_wide: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !s_nxt.soft_reset && s_r.spacing && aggr_ctrl[0][0]
            && src_status[0][5:0] == 6'h20 && src_enable[0][5])
        |=> group_vector_addr[0] ==
            18'({$past(aggr_ctrl[0][17:1]), 1'b0} + 18'h00a00))
        else $error("wide spacing vector wrong");

    a_freeze_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        !clk_en |=> s_r == $past(s_r))
        else $error("state moved while clock enable low");

    a_stat_set_wins: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !s_nxt.soft_reset && rise_c[0]) |=> s_r.stat[0])
        else $error("active rise not recorded");

    a_stat_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !s_nxt.soft_reset && wr && addr == 12'h514 && wdata[0]
            && !rise_c[0]) |=> !s_r.stat[0])
        else $error("status write one did not clear");

    a_irq_level: assert property (
        @(posedge clk) disable iff (!rst_n)
        irq == |(s_r.stat & s_r.mask))
        else $error("irq differs from masked status");

    // -----------------------------------------------------------------
    // register reads
    // -----------------------------------------------------------------
    a_read_enable: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && rd && addr == 12'h50c && !s_nxt.soft_reset)
        |=> rdata[18:0] == $past(s_r.enable))
        else $error("enable clear read wrong");

    a_read_set_reg: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && rd && addr == 12'h508 && !s_nxt.soft_reset)
        |=> rdata[18:0] == $past(s_r.enable))
        else $error("enable set read wrong");

    a_read_pending: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && rd && addr == 12'h504 && !s_nxt.soft_reset)
        |=> rdata[18:0] == $past(s_r.pending))
        else $error("pending read wrong");

    a_read_active: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && rd && addr == 12'h510 && !s_nxt.soft_reset)
        |=> rdata[18:0] == $past(s_r.active))
        else $error("active read wrong");

    a_read_control: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && rd && addr == 12'h500 && !s_nxt.soft_reset)
        |=> rdata == {23'h0, $past(s_r.spacing), 7'h0, $past(s_r.soft_reset)})
        else $error("control read wrong");

    a_unmapped_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && rd && addr == 12'h600) |=> rdata == 32'h00000000)
        else $error("unmapped read not zero");

    a_idle_rdata: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !rd) |=> rdata == 32'h00000000)
        else $error("read data outside read cycle");

    a_reserved_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        rd |=> rdata[31:19] == 13'h0000)
        else $error("reserved bits not zero");
endmodule

/* irq_core_model.sv */
// processor core model that fetches the lowest requesting group's vector
`timescale 1ns/1ps
module irq_core_model (
    // clock and vectors from the block
    input wire logic clk,
    input wire logic [18:0] group_vector_req,
    input wire logic [18:0][17:0] group_vector_addr,
    // what the core would fetch
    output logic taken,
    output logic [17:0] taken_addr
);
    // lowest group wins, since the core priority logic is not modelled
    always_ff @(posedge clk) begin
        taken <= |group_vector_req;
        taken_addr <= 18'h00000;
        for (int g = 18; g >= 0; g--) begin
            if (group_vector_req[g]) begin
                taken_addr <= group_vector_addr[g];
            end
        end
    end
endmodule

/* irq_group_ctrl_tb_top.sv */
// self-checking bench for the group control block
`timescale 1ns/1ps
module irq_group_ctrl_tb_top;
    logic clk, rst_n, wr, rd, irq, taken;
    logic clk_en;
    logic [11:0] addr;
    logic [31:0] wdata, rdata;
    logic [18:0][30:0] src_status, src_enable;
    logic [18:0][17:0] aggr_ctrl, group_vector_addr;
    logic [18:0] group_vector_req;
    logic [17:0] taken_addr;
    int failures = 0;
    int checks = 0;
    irq_group_ctrl irq_group_ctrl_inst (.clk(clk), .rst_n(rst_n),
        .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .src_status(src_status), .src_enable(src_enable),
        .aggr_ctrl(aggr_ctrl), .group_vector_req(group_vector_req),
        .group_vector_addr(group_vector_addr), .irq(irq));
    irq_core_model irq_core_model_inst (.clk(clk),
        .group_vector_req(group_vector_req),
        .group_vector_addr(group_vector_addr), .taken(taken),
        .taken_addr(taken_addr));
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check("register read", rdata, exp);
    endtask
    // two registered stages: write lands, then the vector follows
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 12'h000;
        wdata = 32'h00000000;
        src_status = '0;
        src_enable = '0;
        aggr_ctrl = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 7; i++) reg_rd(12'h500 + 12'(4 * i), 0);
        reg_rd(12'h600, 32'h00000000);
        // a write while the clock enable is low must not land
        @(posedge clk);
        clk_en <= 1'b0;
        reg_wr(12'h508, 32'h00000001);
        clk_en <= 1'b1;
        reg_rd(12'h508, 32'h00000000);
        @(posedge clk);
        src_status[0] <= 31'h00000020;
        src_status[18] <= 31'h00000001;
        src_enable[0] <= 31'h00000020;
        aggr_ctrl[0] <= 18'h00101;
        settle();
        reg_rd(12'h504, 32'h00040001);
        check("req while disabled", 32'(group_vector_req), 0);
        reg_wr(12'h508, 32'h00000001);
        reg_wr(12'h508, 32'h00000000);
        reg_rd(12'h50c, 32'h00000001);
        settle();
        check("vector req", 32'(group_vector_req), 32'h1);
        check("vector at 8", 32'(group_vector_addr[0]), 32'h128);
        check("core fetch", 32'(taken_addr), 32'h128);
        check("core taken", 32'(taken), 32'h1);
        reg_wr(12'h500, 32'hfffffffe);
        reg_rd(12'h500, 32'h00000100);
        settle();
        check("vector at 512", 32'(group_vector_addr[0]), 32'hb00);
        reg_wr(12'h518, 32'h00000001);
        reg_rd(12'h514, 32'h00000001);
        #1;
        check("irq raised", 32'(irq), 32'h1);
        reg_wr(12'h514, 32'h00000001);
        settle();
        check("irq cleared", 32'(irq), 32'h0);
        reg_rd(12'h510, 32'h00000001);
        // more groups: result at position 30 and at position 1
        @(posedge clk);
        src_status[1] <= 31'h40000000;
        src_enable[1] <= 31'h40000000;
        src_status[4] <= 31'h00000006;
        src_enable[4] <= 31'h00000002;
        aggr_ctrl[4] <= 18'h00001;
        reg_wr(12'h508, 32'h0000001e);
        settle();
        check("groups on", 32'(group_vector_req), 32'h13);
        check("vector g4", 32'(group_vector_addr[4]), 32'h200);
        reg_rd(12'h504, 32'h00040013);
        reg_wr(12'h50c, 32'h0000001e);
        reg_rd(12'h50c, 32'h00000001);
        settle();
        check("groups off", 32'(group_vector_req), 32'h1);
        @(posedge clk);
        src_status[1] <= '0;
        src_status[4] <= '0;
        reg_wr(12'h50c, 32'h00000001);
        settle();
        check("req disabled", 32'(group_vector_req), 0);
        reg_rd(12'h510, 32'h00000000);
        reg_rd(12'h508, 32'h00000000);
        @(posedge clk);
        aggr_ctrl[0] <= 18'h00100;
        reg_wr(12'h508, 32'h00000001);
        settle();
        check("base only", 32'(group_vector_addr[0]), 32'h100);
        check("irq again", 32'(irq), 32'h1);
        reg_wr(12'h500, 32'h00000001);
        settle();
        check("req in soft reset", 32'(group_vector_req), 0);
        check("irq in soft reset", 32'(irq), 0);
        reg_rd(12'h508, 32'h00000000);
        reg_rd(12'h500, 32'h00000001);
        reg_wr(12'h500, 32'h00000000);
        reg_rd(12'h504, 32'h00040001);
        // mid-run power-on reset drops the enables again
        reg_wr(12'h508, 32'h00000001);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        reg_rd(12'h508, 32'h00000000);
        settle();
        check("req after reset", 32'(group_vector_req), 0);
        check("irq after reset", 32'(irq), 0);
        report_and_stop();
    end
endmodule
